// ==== rtl/gps_stamp_defs.vh ====
// Constants for the GPS time packet stamper
`ifndef GPS_STAMP_DEFS_VH
`define GPS_STAMP_DEFS_VH
`define CLK_HZ          32'd20000000
`define CLK_PER_US      8'd20
`define US_PER_SEC      20'd1000000
`define TICK_CYCLES     25'd20000000
`define YEAR_RST        8'h00
`define MONTH_RST       8'h01
`define DAY_RST         8'h01
`define HMS_RST         8'h00
`define MONTH_MAX       8'h0c
`define HOUR_MAX        8'h17
`define MINSEC_MAX      8'h3b
`define ASCII_ZERO      8'h30
`define FRAME_HDR_LEN   11'd42
`define UDP_DATA_LEN    11'd512
`define FRAME_LEN       11'd554
`define PAY_TIME_END    11'd18
`define PAY_NMEA_END    11'd102
`define PAY_FILL_END    11'd506
`define PAY_FIX_IDX     11'd506
`define PAY_LOCK_IDX    11'd507
`define FILL_BYTE       8'hdf
`define SYNC_BYTE0      8'hff
`define SYNC_BYTE1      8'hee
`define BCAST_BYTE      8'hff
`define PAY_ASCII_END   11'd14
`define ETHTYPE_HI      8'h08
`define ETHTYPE_LO      8'h00
`define IP_VER_IHL      8'h45
`define IP_TOS          8'h00
`define IP_TOTAL_LEN    16'd540
`define IP_FLAGS_DF     8'h40
`define IP_TTL          8'h40
`define IP_PROTO_UDP    8'h11
`define IP_SRC_ADDR     32'hc0a801c9
`define IP_DST_ADDR     32'hffffffff
`define UDP_SRC_PORT    16'h2710
`define UDP_DST_PORT    16'h277e
`define UDP_LEN         16'h0208
`define NMEA_LEN        7'd84
`define PPS_LOST_SECS   3'd2
`endif

// ==== rtl/nmea_store.v ====
// Small memory that holds the last copied NMEA sentence
module nmea_store (
  // Clock
  input  wire       clk_i,
  // Write port
  input  wire       we_i,
  input  wire [6:0] waddr_i,
  input  wire [7:0] wdata_i,
  // Read port, data registered
  input  wire [6:0] raddr_i,
  output reg  [7:0] rdata_o
);
  reg [7:0] mem [0:127];

  // Write and registered read
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // nmea_store

// ==== rtl/gps_time_packet_stamper.v ====
// GPS time packet framer and second-resolution time keeper
// Function
// - Stamp six time bytes, year less 2000.
// - Order year month day hour minute second.
// - Sequence field only when option enabled.
// - Sequence 32 bits, low byte first.
// - One GPS packet per second, little endian.
// - Internal tick triggers packet before NMEA.
// - Free time starts 00-01-01 00:00:00.
// - Tick phase locks to PPS once synced.
// - Synced time comes from NMEA sentences.
// - GPS packet date YMD, time SMH.
// - At PPS use last NMEA plus one second.
// - On GPS loss keep ticking, accept drift.
// - Source 192.168.1.201, destination broadcast.
// - 42-byte header, broadcast MAC, type 0800.
// - UDP ports 10000 and 10110.
// - UDP length 0x208.
// - IPv4 fields fixed, DF, TTL 64, UDP.
// - Microsecond count within current second.
// - 512-byte payload with NMEA, fill, flags.
`include "gps_stamp_defs.vh"
module gps_time_packet_stamper (
  // Clock and reset
  input  wire        mclk_i,
  input  wire        nrst_i,
  // Timing inputs from GPS receiver
  input  wire        pps_i,
  // Parsed NMEA time, same clock domain
  input  wire        nmea_valid_i,
  input  wire [7:0]  nmea_year_i,
  input  wire [7:0]  nmea_month_i,
  input  wire [7:0]  nmea_day_i,
  input  wire [7:0]  nmea_hour_i,
  input  wire [7:0]  nmea_min_i,
  input  wire [7:0]  nmea_sec_i,
  input  wire [7:0]  nmea_fix_i,
  // NMEA sentence bytes to copy
  input  wire        nmea_byte_we_i,
  input  wire [6:0]  nmea_byte_addr_i,
  input  wire [7:0]  nmea_byte_i,
  // Configuration
  input  wire [47:0] src_mac_i,
  input  wire        seq_en_i,
  // Point cloud stamp interface
  input  wire        pc_sent_i,
  output reg  [47:0] pc_datetime_o,
  output reg  [31:0] pc_usec_o,
  output reg  [31:0] pc_seq_o,
  output wire        pc_seq_valid_o,
  // GPS frame byte stream
  input  wire        tx_ready_i,
  output wire        tx_valid_o,
  output reg  [7:0]  tx_data_o,
  output wire        tx_last_o,
  // Status
  output reg         pps_locked_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SEND = 2'd1;
  localparam ST_READ = 2'd2;

  reg        rst_s1_q, rst_n_q;
  reg        pps_s1_q, pps_s2_q, pps_d_q;
  reg [24:0] tick_cnt_q;
  reg [7:0]  us_div_q;
  reg [19:0] us_cnt_q;
  reg [7:0]  yr_q, mo_q, dy_q, hr_q, mi_q, se_q;
  reg [7:0]  n_yr_q, n_mo_q, n_dy_q, n_hr_q, n_mi_q, n_se_q, fix_q;
  reg        have_nmea_q;
  reg [2:0]  pps_miss_q;
  reg [1:0]  st_q;
  reg [10:0] idx_q;
  reg [31:0] seq_q;
  reg [7:0]  byte_d;
  wire [7:0] nmea_rd;
  wire       pps_rise = pps_s2_q & ~pps_d_q;
  wire       tick_free = (tick_cnt_q == `TICK_CYCLES - 25'd1);
  wire       lock_now = pps_locked_o | (pps_rise & have_nmea_q);
  wire       tick = lock_now ? pps_rise : tick_free;
  wire [10:0] pay = idx_q - `FRAME_HDR_LEN;

  // Reset release through two flops
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // PPS synchroniser and edge detect
  always @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pps_s1_q <= 1'b0;
      pps_s2_q <= 1'b0;
      pps_d_q  <= 1'b0;
    end else begin
      pps_s1_q <= pps_i;
      pps_s2_q <= pps_s1_q;
      pps_d_q  <= pps_s2_q;
    end
  end

  // Days in month, leap years by divisibility by four
  function [7:0] mdays;
    input [7:0] m;
    input [7:0] y;
    begin
      case (m)
        8'h02:   mdays = (y[1:0] == 2'b00) ? 8'h1d : 8'h1c;
        8'h04, 8'h06, 8'h09, 8'h0b: mdays = 8'h1e;
        default: mdays = 8'h1f;
      endcase
    end
  endfunction

  // ASCII tens digit and units digit of a 0..99 value
  function [15:0] ascii2;
    input [7:0] v;
    begin
      ascii2 = {`ASCII_ZERO + v / 8'd10, `ASCII_ZERO + v % 8'd10};
    end
  endfunction

  // Free tick counter, restarted by PPS when locked
  always @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tick_cnt_q <= 25'h0;
    end else if (tick || tick_free) begin
      tick_cnt_q <= 25'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 25'd1;
    end
  end

  // Microsecond count within the second
  always @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      us_div_q <= 8'h0;
      us_cnt_q <= 20'h0;
    end else if (tick) begin
      us_div_q <= 8'h0;
      us_cnt_q <= 20'h0;
    end else if (us_div_q == `CLK_PER_US - 8'd1) begin
      us_div_q <= 8'h0;
      if (us_cnt_q != `US_PER_SEC) begin
        us_cnt_q <= us_cnt_q + 20'd1;
      end
    end else begin
      us_div_q <= us_div_q + 8'd1;
    end
  end

  // Latch last parsed NMEA time
  always @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      n_yr_q <= `YEAR_RST;
      n_mo_q <= `MONTH_RST;
      n_dy_q <= `DAY_RST;
      n_hr_q <= `HMS_RST;
      n_mi_q <= `HMS_RST;
      n_se_q <= `HMS_RST;
      fix_q  <= 8'h00;
      have_nmea_q <= 1'b0;
    end else if (nmea_valid_i) begin
      n_yr_q <= nmea_year_i;
      n_mo_q <= nmea_month_i;
      n_dy_q <= nmea_day_i;
      n_hr_q <= nmea_hour_i;
      n_mi_q <= nmea_min_i;
      n_se_q <= nmea_sec_i;
      fix_q  <= nmea_fix_i;
      have_nmea_q <= 1'b1;
    end else if (pps_miss_q == `PPS_LOST_SECS) begin
      have_nmea_q <= 1'b0;
    end
  end

  // Lock state: PPS seen with NMEA, dropped after missed pulses
  always @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pps_locked_o <= 1'b0;
      pps_miss_q   <= 3'd0;
    end else if (pps_rise) begin
      pps_miss_q <= 3'd0;
      if (have_nmea_q) begin
        pps_locked_o <= 1'b1;
      end
    end else if (tick_free) begin
      if (pps_miss_q == `PPS_LOST_SECS) begin
        pps_locked_o <= 1'b0;
      end else begin
        pps_miss_q <= pps_miss_q + 3'd1;
      end
    end
  end

  // Base time: last NMEA at a pulse, else own count
  wire       use_nmea = pps_rise & have_nmea_q;
  wire [7:0] b_yr = use_nmea ? n_yr_q : yr_q;
  wire [7:0] b_mo = use_nmea ? n_mo_q : mo_q;
  wire [7:0] b_dy = use_nmea ? n_dy_q : dy_q;
  wire [7:0] b_hr = use_nmea ? n_hr_q : hr_q;
  wire [7:0] b_mi = use_nmea ? n_mi_q : mi_q;
  wire [7:0] b_se = use_nmea ? n_se_q : se_q;
  // Carry chain for the added second
  wire       c_se = (b_se >= `MINSEC_MAX);
  wire       c_mi = c_se && (b_mi >= `MINSEC_MAX);
  wire       c_hr = c_mi && (b_hr >= `HOUR_MAX);
  wire       c_dy = c_hr && (b_dy >= mdays(b_mo, b_yr));
  wire       c_mo = c_dy && (b_mo >= `MONTH_MAX);
  // Time of day, one second added on each tick
  always @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      yr_q <= `YEAR_RST;
      mo_q <= `MONTH_RST;
      dy_q <= `DAY_RST;
      hr_q <= `HMS_RST;
      mi_q <= `HMS_RST;
      se_q <= `HMS_RST;
    end else if (tick) begin
      se_q <= c_se ? `HMS_RST : b_se + 8'd1;
      mi_q <= c_mi ? `HMS_RST : b_mi + {7'h00, c_se};
      hr_q <= c_hr ? `HMS_RST : b_hr + {7'h00, c_mi};
      dy_q <= c_dy ? `DAY_RST : b_dy + {7'h00, c_hr};
      mo_q <= c_mo ? `MONTH_RST : b_mo + {7'h00, c_dy};
      yr_q <= b_yr + {7'h00, c_mo};
    end
  end

  // Point cloud stamp outputs and sequence counter
  always @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pc_datetime_o <= 48'h0;
      pc_usec_o     <= 32'h0;
      seq_q         <= 32'h0;
      pc_seq_o      <= 32'h0;
    end else begin
      pc_datetime_o <= {yr_q, mo_q, dy_q, hr_q, mi_q, se_q};
      pc_usec_o     <= {12'h000, us_cnt_q};
      pc_seq_o      <= seq_q;
      if (pc_sent_i && seq_en_i) begin
        seq_q <= seq_q + 32'd1;
      end
    end
  end
  assign pc_seq_valid_o = seq_en_i;

  // Header constants as vectors, so each byte is a plain slice
  wire [15:0] ip_len  = `IP_TOTAL_LEN;
  wire [31:0] ip_src  = `IP_SRC_ADDR;
  wire [31:0] ip_dst  = `IP_DST_ADDR;
  wire [47:0] udp_k   = {`UDP_SRC_PORT, `UDP_DST_PORT, `UDP_LEN};
  // IPv4 header checksum over constant fields, zero identification
  wire [31:0] ip_sum0 = {16'h0, `IP_VER_IHL, `IP_TOS} + {16'h0, ip_len}
                      + {16'h0, `IP_FLAGS_DF, 8'h00} + {16'h0, `IP_TTL, `IP_PROTO_UDP}
                      + {16'h0, ip_src[31:16]} + {16'h0, ip_src[15:0]}
                      + {16'h0, ip_dst[31:16]} + {16'h0, ip_dst[15:0]};
  wire [31:0] ip_sum1 = {16'h0, ip_sum0[15:0]} + {16'h0, ip_sum0[31:16]};
  wire [15:0] ip_csum = ~(ip_sum1[15:0] + ip_sum1[31:16]);

  // ASCII time bytes, units digit first: Y M D then S M H
  wire [95:0] t_asc = {ascii2(hr_q), ascii2(mi_q), ascii2(se_q),
                       ascii2(dy_q), ascii2(mo_q), ascii2(yr_q)};
  // Frame byte mux
  always @* begin
    byte_d = 8'h00;
    case (idx_q)
      11'd0, 11'd1, 11'd2, 11'd3, 11'd4, 11'd5: byte_d = `BCAST_BYTE;
      11'd6:  byte_d = src_mac_i[47:40];
      11'd7:  byte_d = src_mac_i[39:32];
      11'd8:  byte_d = src_mac_i[31:24];
      11'd9:  byte_d = src_mac_i[23:16];
      11'd10: byte_d = src_mac_i[15:8];
      11'd11: byte_d = src_mac_i[7:0];
      11'd12: byte_d = `ETHTYPE_HI;
      11'd13: byte_d = `ETHTYPE_LO;
      11'd14: byte_d = `IP_VER_IHL;
      11'd15: byte_d = `IP_TOS;
      11'd16: byte_d = ip_len[15:8];
      11'd17: byte_d = ip_len[7:0];
      11'd20: byte_d = `IP_FLAGS_DF;
      11'd22: byte_d = `IP_TTL;
      11'd23: byte_d = `IP_PROTO_UDP;
      11'd24: byte_d = ip_csum[15:8];
      11'd25: byte_d = ip_csum[7:0];
      11'd26: byte_d = ip_src[31:24];
      11'd27: byte_d = ip_src[23:16];
      11'd28: byte_d = ip_src[15:8];
      11'd29: byte_d = ip_src[7:0];
      11'd30: byte_d = ip_dst[31:24];
      11'd31: byte_d = ip_dst[23:16];
      11'd32: byte_d = ip_dst[15:8];
      11'd33: byte_d = ip_dst[7:0];
      11'd34: byte_d = udp_k[47:40];
      11'd35: byte_d = udp_k[39:32];
      11'd36: byte_d = udp_k[31:24];
      11'd37: byte_d = udp_k[23:16];
      11'd38: byte_d = udp_k[15:8];
      11'd39: byte_d = udp_k[7:0];
      // Bytes 40 and 41: UDP checksum left zero
      default: begin
        if (pay == 11'd0) byte_d = `SYNC_BYTE0;
        else if (pay == 11'd1) byte_d = `SYNC_BYTE1;
        else if (pay < `PAY_ASCII_END) byte_d = t_asc[{pay[3:0] - 4'd2, 3'b000} +: 8];
        else if (pay < `PAY_TIME_END) byte_d = 8'h00;
        else if (pay < `PAY_NMEA_END) byte_d = nmea_rd;
        else if (pay < `PAY_FILL_END) byte_d = `FILL_BYTE;
        else if (pay == `PAY_FIX_IDX) byte_d = fix_q;
        else if (pay == `PAY_LOCK_IDX) byte_d = {7'h00, pps_locked_o};
        else byte_d = 8'h00;
      end
    endcase
  end

  // NMEA copy memory, read one byte ahead of the frame index
  wire [10:0] next_pay = pay + 11'd1 - `PAY_TIME_END;
  nmea_store u_nmea (
    .clk_i   (mclk_i),
    .we_i    (nmea_byte_we_i),
    .waddr_i (nmea_byte_addr_i),
    .wdata_i (nmea_byte_i),
    .raddr_i (next_pay[6:0]),
    .rdata_o (nmea_rd)
  );

  // Frame sender: one frame per tick, stalls on tx_ready_i
  always @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q      <= ST_IDLE;
      idx_q     <= 11'h0;
      tx_data_o <= 8'h00;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (tick) begin
            st_q  <= ST_READ;
            idx_q <= 11'h0;
          end
        end
        ST_READ: begin
          tx_data_o <= byte_d;
          st_q      <= ST_SEND;
        end
        ST_SEND: begin
          if (tx_ready_i) begin
            if (idx_q == `FRAME_LEN - 11'd1) begin
              st_q <= ST_IDLE;
            end else begin
              idx_q <= idx_q + 11'd1;
              st_q  <= ST_READ;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign tx_valid_o = (st_q == ST_SEND);
  assign tx_last_o  = (st_q == ST_SEND) && (idx_q == `FRAME_LEN - 11'd1);
endmodule // gps_time_packet_stamper

// ==== test/gps_stamp_checker_asserts.sv ====
// Port-level checker for the GPS time packet stamper
module gps_stamp_checker (
  // Clock, reset and inputs
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        pps_i,
  input wire logic        seq_en_i,
  input wire logic        pc_sent_i,
  input wire logic        tx_ready_i,
  // Outputs watched
  input wire logic [47:0] pc_datetime_o,
  input wire logic [31:0] pc_usec_o,
  input wire logic [31:0] pc_seq_o,
  input wire logic        pc_seq_valid_o,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_last_o,
  input wire logic        pps_locked_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic [2:0] up_q;
  logic [9:0] nby_q;
  logic       busy_q;
  // Cycles since release, bytes accepted, frame in progress
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      up_q   <= 3'h0;
      nby_q  <= 10'h000;
      busy_q <= 1'b0;
    end else begin
      if (up_q != 3'h7) up_q <= up_q + 3'h1;
      if (tx_valid_o && tx_ready_i) begin
        nby_q  <= tx_last_o ? 10'h000 : nby_q + 10'h001;
        busy_q <= !tx_last_o;
      end
    end
  end
  a_seq_present: assert property (pc_seq_valid_o == seq_en_i)
    else $error("sequence field flag differs from option");
  a_seq_step: assert property (!pc_sent_i ##1 (seq_en_i && pc_sent_i) ##1 !pc_sent_i
    |=> pc_seq_o == $past(pc_seq_o, 2) + 32'h1)
    else $error("sequence did not advance by one");
  a_seq_hold: assert property ((!(seq_en_i && pc_sent_i))[*3] |-> $stable(pc_seq_o))
    else $error("sequence moved without a packet");
  a_usec_max: assert property (pc_usec_o <= 32'd1000000)
    else $error("microsecond count above one second");
  a_date_range: assert property (up_q == 3'h7 |-> pc_datetime_o[39:32] inside {[1:12]}
    && pc_datetime_o[31:24] inside {[1:31]})
    else $error("month or day out of range");
  a_clock_range: assert property (up_q == 3'h7 |-> pc_datetime_o[23:16] <= 8'h17
    && pc_datetime_o[15:8] <= 8'h3b && pc_datetime_o[7:0] <= 8'h3b)
    else $error("hour minute or second out of range");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i
    |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
    else $error("stalled byte not held");
  a_frame_len: assert property (tx_valid_o && tx_ready_i && tx_last_o
    |-> nby_q == 10'd553)
    else $error("frame length not 554 bytes");
  a_lock_pps: assert property ($rose(pps_locked_o) |-> pps_i)
    else $error("lock set away from a pulse");
  a_pps_frame: assert property ($rose(pps_i) && pps_locked_o && !tx_valid_o && !busy_q
    |-> ##[2:8] tx_valid_o)
    else $error("no packet after locked pulse");
endmodule // gps_stamp_checker

bind gps_time_packet_stamper gps_stamp_checker u_chk (.mclk_i, .nrst_i, .pps_i, .seq_en_i,
  .pc_sent_i, .tx_ready_i, .pc_datetime_o, .pc_usec_o, .pc_seq_o, .pc_seq_valid_o,
  .tx_valid_o, .tx_data_o, .tx_last_o, .pps_locked_o);

// ==== test/gps_rx_model.sv ====
// Behavioural GPS receiver: sentence copy, parsed time and pulse
module gps_rx_model (
  // Clock
  input  wire logic        mclk_i,
  // Receiver outputs
  output logic             pps_o,
  output logic             valid_o,
  output logic [47:0]      time_o,
  output logic [7:0]       fix_o,
  output logic             we_o,
  output logic [6:0]       addr_o,
  output logic [7:0]       byte_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {pps_o, valid_o, we_o} = 3'h0;
    time_o = 48'h0;
    fix_o  = 8'h0;
    addr_o = 7'h0;
    byte_o = 8'h0;
  end
  // Sentence of the last second, then its parsed time
  task automatic send_nmea(input logic [47:0] t);
    for (int i = 0; i < 84; i++) begin
      @(posedge mclk_i) #1;
      we_o   = 1'b1;
      addr_o = 7'(i);
      byte_o = 8'h20 + 8'(i);
    end
    @(posedge mclk_i) #1;
    we_o    = 1'b0;
    addr_o  = ~addr_o;
    byte_o  = ~byte_o;
    time_o  = t;
    fix_o   = 8'h41;
    valid_o = 1'b1;
    @(posedge mclk_i) #1;
    valid_o = 1'b0;
    time_o  = ~t; // Stale fields are not shown
    fix_o   = 8'hbe;
  endtask
  // Pulse comes after the sentence of the previous second
  task automatic pps_pulse();
    @(posedge mclk_i) #1;
    pps_o = 1'b1;
    repeat (10) @(posedge mclk_i);
    #1 pps_o = 1'b0;
  endtask
endmodule // gps_rx_model

// ==== test/gps_time_packet_stamper_tb.sv ====
// Self-checking testbench for the GPS time packet stamper
module gps_time_packet_stamper_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        seq_en_i = 1'b0;
  logic        pc_sent_i = 1'b0;
  logic        tx_ready_i = 1'b0;
  wire         pps, nv, we;
  wire  [47:0] nt;
  wire  [7:0]  nf, wd, tx_data_o;
  wire  [6:0]  wa;
  wire  [47:0] pc_datetime_o;
  wire  [31:0] pc_usec_o, pc_seq_o;
  wire         pc_seq_valid_o, tx_valid_o, tx_last_o, pps_locked_o;
  logic [7:0]  frame [0:1107];
  int          nb = 0, last_at = -1, sc = 0, n_fail = 0, num_checks = 0;
  // Expected 42-byte header, IP checksum bytes skipped in the compare
  localparam logic [335:0] HX = {48'hffffffffffff, 48'h021122334455, 16'h0800,
    32'h4500021c, 32'h00004000, 16'h4011, 16'h0000, 32'hc0a801c9, 32'hffffffff,
    32'h2710277e, 16'h0208, 16'h0000};
  always #25 mclk_i = ~mclk_i;
  gps_rx_model rx (.mclk_i(mclk_i), .pps_o(pps), .valid_o(nv), .time_o(nt), .fix_o(nf),
    .we_o(we), .addr_o(wa), .byte_o(wd));
  gps_time_packet_stamper dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .pps_i(pps),
    .nmea_valid_i(nv), .nmea_year_i(nt[47:40]), .nmea_month_i(nt[39:32]),
    .nmea_day_i(nt[31:24]), .nmea_hour_i(nt[23:16]), .nmea_min_i(nt[15:8]),
    .nmea_sec_i(nt[7:0]), .nmea_fix_i(nf), .nmea_byte_we_i(we), .nmea_byte_addr_i(wa),
    .nmea_byte_i(wd), .src_mac_i(48'h021122334455), .seq_en_i(seq_en_i),
    .pc_sent_i(pc_sent_i), .pc_datetime_o(pc_datetime_o), .pc_usec_o(pc_usec_o),
    .pc_seq_o(pc_seq_o), .pc_seq_valid_o(pc_seq_valid_o), .tx_ready_i(tx_ready_i),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
    .pps_locked_o(pps_locked_o));
  // Sink stalls one cycle in three and records accepted bytes
  always @(posedge mclk_i) begin
    sc <= sc + 1;
    tx_ready_i <= #1 (sc % 3 != 2);
    if (tx_valid_o === 1'b1 && tx_ready_i) begin
      frame[nb] <= tx_data_o;
      if (tx_last_o === 1'b1) last_at <= nb;
      nb <= nb + 1;
    end
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Two ASCII digits, units digit first
  function automatic logic [15:0] asc(input logic [7:0] v);
    return {8'h30 + v % 8'd10, 8'h30 + v / 8'd10};
  endfunction
  task automatic pulse_sent();
    @(posedge mclk_i) #1 pc_sent_i = 1'b1;
    @(posedge mclk_i) #1 pc_sent_i = 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic t_reset();
    chk("reset time", pc_datetime_o, 48'h000101000000);
    chk("reset lock", pps_locked_o, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_seq();
    repeat (2) pulse_sent();
    chk("seq absent", pc_seq_valid_o, 1'b0);
    chk("seq idle", pc_seq_o, 32'h0);
    #1 seq_en_i = 1'b1;
    repeat (3) pulse_sent();
    chk("seq present", pc_seq_valid_o, 1'b1);
    chk("seq count", pc_seq_o, 32'h3);
    $display("test sequence done");
  endtask
  task automatic t_frame(input logic [47:0] nmea_t, input logic [47:0] exp_t);
    logic [7:0]  p [0:17];
    logic [31:0] s;
    int          b, bad;
    rx.send_nmea(nmea_t);
    b = nb;
    rx.pps_pulse();
    repeat (190) @(posedge mclk_i);
    #1 chk("usec", pc_usec_o >= 32'd8 && pc_usec_o <= 32'd10, 1'b1);
    for (int k = 0; k < 4000 && nb < b + 554; k++) @(posedge mclk_i);
    #1 chk("frame end", last_at, b + 553);
    for (int i = 0; i < 42; i++) if (i < 24 || i > 25)
      chk("header", frame[b + i], HX[8 * (41 - i) +: 8]);
    s = 32'h0;
    for (int i = 0; i < 10; i++) s += {frame[b + 14 + 2 * i], frame[b + 15 + 2 * i]};
    s = s[15:0] + s[31:16];
    s = s[15:0] + s[31:16];
    chk("ip checksum", s[15:0], 16'hffff);
    p[0] = 8'hff;
    p[1] = 8'hee;
    {p[2], p[3], p[4], p[5], p[6], p[7]} = {asc(exp_t[47:40]), asc(exp_t[39:32]),
      asc(exp_t[31:24])};
    {p[8], p[9], p[10], p[11], p[12], p[13]} = {asc(exp_t[7:0]), asc(exp_t[15:8]),
      asc(exp_t[23:16])};
    for (int i = 14; i < 18; i++) p[i] = 8'h00;
    for (int i = 0; i < 18; i++) chk("time field", frame[b + 42 + i], p[i]);
    for (int i = 0; i < 84; i++) chk("nmea copy", frame[b + 60 + i], 8'h20 + 8'(i));
    bad = 0;
    for (int i = 144; i < 548; i++) if (frame[b + i] !== 8'hdf) bad++;
    for (int i = 550; i < 554; i++) if (frame[b + i] !== 8'h00) bad++;
    chk("fill and tail", bad, 0);
    chk("fix", frame[b + 548], 8'h41);
    chk("lock byte", frame[b + 549], 8'h01);
    chk("stamp", pc_datetime_o, exp_t);
    chk("locked", pps_locked_o, 1'b1);
    $display("test frame done");
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk_i);
    #1 nrst_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    #1 t_reset();
    t_seq();
    t_frame(48'h170c1f173b3b, 48'h180101000000);
    t_frame(48'h18021c173b3b, 48'h18021d000000);
    print_verdict();
  end
  // Watchdog
  initial begin
    #(20000 * 50);
    n_fail++;
    print_verdict();
  end
endmodule // gps_time_packet_stamper_tb
